// ---- hw/tsr_link.sv ----
// link-clock side: pointer decode, control write, read data, event toggles
module tsr_link #(
  parameter logic [15:0] ID_WORD = 16'h0000
) (
  input  wire logic        link_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  ptr_in,
  input  wire logic        wr_stb_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        rd_stb_in,
  input  wire logic        ara_done_in,
  output logic      [15:0] rd_data_out,
  tsr_xfer_if.link         xf
);
  logic [2:0] ctrl_r;
  logic [3:0] stat_m_r;
  logic       req_s;
  logic       wr_tgl_r;
  logic       rd_tgl_r;
  logic       ara_tgl_r;
  logic       ack_tgl_r;

  assign xf.wr_tgl    = wr_tgl_r;
  assign xf.rd_tgl    = rd_tgl_r;
  assign xf.ara_tgl   = ara_tgl_r;
  assign xf.ack_tgl   = ack_tgl_r;
  assign xf.ctrl_bits = ctrl_r;

  // control bits held here so a read right after a write sees them
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r   <= tsr_pkg::CTRL_RESET[tsr_pkg::BIT_TO_OFF:tsr_pkg::BIT_RES_LO];
      wr_tgl_r <= 1'b0;
    end else if (wr_stb_in && ptr_in == tsr_pkg::PTR_CTRL) begin
      // status and reserved positions are not stored
      ctrl_r   <= wr_data_in[tsr_pkg::BIT_TO_OFF:tsr_pkg::BIT_RES_LO];
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // read of status and alert response become toggles for the core
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_tgl_r  <= 1'b0;
      ara_tgl_r <= 1'b0;
    end else begin
      if (rd_stb_in && ptr_in == tsr_pkg::PTR_CTRL) begin
        rd_tgl_r <= ~rd_tgl_r;
      end
      if (ara_done_in) begin
        ara_tgl_r <= ~ara_tgl_r;
      end
    end
  end

  tsr_sync #(.W(1), .RST(1'b0)) u_req_sync (
    .clk_in    (link_clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (xf.req_tgl),
    .q_out     (req_s)
  );

  // take a new status snapshot, then acknowledge it
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stat_m_r  <= tsr_pkg::CTRL_RESET[tsr_pkg::BIT_ALARM:tsr_pkg::BIT_DONE];
      ack_tgl_r <= 1'b0;
    end else if (req_s != ack_tgl_r) begin
      stat_m_r  <= xf.stat_bits;
      ack_tgl_r <= req_s;
    end
  end

  // read word registered one link edge after the pointer
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= tsr_pkg::RD_NONE;
    end else if (ptr_in == tsr_pkg::PTR_CTRL) begin
      rd_data_out <= {8'h00, ctrl_r, 1'b0, stat_m_r};
    end else if (ptr_in == tsr_pkg::PTR_ID) begin
      rd_data_out <= ID_WORD;
    end else begin
      rd_data_out <= tsr_pkg::RD_NONE;
    end
  end
endmodule

// ---- hw/tsr_pkg.sv ----
// shared constants for the sensor control/status and identification regs
// How it works
// - bit 7 set switches off the bus-idle timers of the serial lines
// - bits 6:5 choose conversion word size, 11 to 14 bits
// - reserved bit 4 always reads as zero
// - alarm status bit 3 mirrors the present alarm pin level
// - alarm released by clear command, under-limit reading, or alert response
// - over-limit flag bit 2 set when temperature exceeds upper limit
// - over-limit flag clears on status read once no longer above limit
// - under-limit flag bit 1 set when temperature below lower limit
// - under-limit flag clears on status read once no longer below limit
// - conversion-done bit 0 is 0 while converting, 1 when finished
// - continuous mode after reset, done flag then always reads 1
// - control/status register at pointer 04h, read/write, resets to 08h
// - identification at 07h, read-only, maker, product, revision fields
// - polarity bit makes alarm pin and status active-high or active-low
// - enable bit low enables alarm pin, high disables it
// - reading above two's-complement upper limit raises alarm and flag
// - single-conversion request starts one conversion only in shutdown
package tsr_pkg;
  localparam logic [7:0]  PTR_CTRL   = 8'h04;
  localparam logic [7:0]  PTR_ID     = 8'h07;
  localparam logic [7:0]  CTRL_RESET = 8'h08;
  localparam logic [15:0] RD_NONE    = 16'h0000;

  // control/status bit positions
  localparam int BIT_TO_OFF = 7;
  localparam int BIT_RES_HI = 6;
  localparam int BIT_RES_LO = 5;
  localparam int BIT_ALARM  = 3;
  localparam int BIT_OVER   = 2;
  localparam int BIT_UNDER  = 1;
  localparam int BIT_DONE   = 0;

  // identification field positions
  localparam int ID_MAKER_LO = 8;
  localparam int ID_PROD_LO  = 4;

  typedef enum logic [1:0] {
    RES_11 = 2'h0,
    RES_12 = 2'h1,
    RES_13 = 2'h2,
    RES_14 = 2'h3
  } tsr_res_e;

  localparam logic [15:0] MASK_11 = 16'hffe0;
  localparam logic [15:0] MASK_12 = 16'hfff0;
  localparam logic [15:0] MASK_13 = 16'hfff8;
  localparam logic [15:0] MASK_14 = 16'hfffc;

  // bits of a reading that the chosen word size keeps
  function automatic logic [15:0] res_mask(input logic [1:0] sel);
    logic [15:0] m;
    m = MASK_11;
    unique case (tsr_res_e'(sel))
      RES_11: m = MASK_11;
      RES_12: m = MASK_12;
      RES_13: m = MASK_13;
      RES_14: m = MASK_14;
    endcase
    return m;
  endfunction
endpackage

// ---- hw/tsr_regs.sv ----
// control/status and identification registers of the temperature sensor
module tsr_regs #(
  parameter logic [7:0] ID_MAKER = 8'h5a, // arbitrary value
  parameter logic [3:0] ID_PROD  = 4'h3,  // arbitrary value
  parameter logic [3:0] ID_REV   = 4'h2   // arbitrary value
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        ARST_N_IN,
  // link side, on the serial clock
  input  wire logic        LINK_CLK_IN,
  input  wire logic [7:0]  PTR_IN,
  input  wire logic        WR_STB_IN,
  input  wire logic [7:0]  WR_DATA_IN,
  input  wire logic        RD_STB_IN,
  input  wire logic        ARA_DONE_IN,
  output logic      [15:0] RD_DATA_OUT,
  // configuration and converter, core clock
  input  wire logic        SHUTDOWN_IN,
  input  wire logic        ONE_SHOT_IN,
  input  wire logic        ALARM_CLEAR_CMD_IN,
  input  wire logic        ALARM_POLARITY_SEL_IN,
  input  wire logic        ALARM_ENABLE_N_IN,
  input  wire logic        CONV_DONE_IN,
  input  wire logic [15:0] TEMP_IN,
  input  wire logic [15:0] UPPER_LIMIT_VALUE_IN,
  input  wire logic [15:0] LOWER_LIMIT_VALUE_IN,
  output logic             CONV_START_OUT,
  output logic             BUS_TIMEOUT_OFF_OUT,
  output logic      [1:0]  RESOLUTION_SEL_OUT,
  output logic      [7:0]  STATUS_OUT,
  // open-drain alarm pin
  input  wire logic        ALARM_PIN_IN,
  output logic             ALARM_PIN_OUT,
  output logic             ALARM_PIN_OE_N_OUT
);
  localparam logic [15:0] ID_WORD = {ID_MAKER, ID_PROD, ID_REV};

  tsr_xfer_if xf ();

  logic       wr_s;
  logic       rd_s;
  logic       ara_s;
  logic       ack_s;
  logic       wr_seen_r;
  logic       rd_seen_r;
  logic       ara_seen_r;
  logic       wr_ev;
  logic       rd_ev;
  logic       ara_ev;
  logic       pin_s;
  logic [2:0] ctrl_r;
  logic       busy_r;
  logic       over_r;
  logic       under_r;
  logic       over_now_r;
  logic       under_now_r;
  logic       alarm_act_r;
  logic       req_tgl_r;
  logic [3:0] snap_r;
  logic [3:0] live;
  logic       done_flag;
  logic       over_hit;
  logic       under_hit;
  logic       snap_ok;
  logic       pin_level_nxt;
  logic [15:0] temp_m;
  logic [15:0] upper_m;
  logic [15:0] lower_m;

  tsr_link #(.ID_WORD(ID_WORD)) u_link (
    .link_clk_in (LINK_CLK_IN),
    .arst_n_in   (ARST_N_IN),
    .ptr_in      (PTR_IN),
    .wr_stb_in   (WR_STB_IN),
    .wr_data_in  (WR_DATA_IN),
    .rd_stb_in   (RD_STB_IN),
    .ara_done_in (ARA_DONE_IN),
    .rd_data_out (RD_DATA_OUT),
    .xf          (xf.link)
  );

  // toggles from the link, each bit crossed on its own
  tsr_sync #(.W(4), .RST(4'h0)) u_tgl_sync (
    .clk_in    (CLOCK_IN),
    .arst_n_in (ARST_N_IN),
    .d_in      ({xf.wr_tgl, xf.rd_tgl, xf.ara_tgl, xf.ack_tgl}),
    .q_out     ({wr_s, rd_s, ara_s, ack_s})
  );

  // pin level comes back from the board, idle high at reset
  tsr_sync #(.W(1), .RST(1'b1)) u_pin_sync (
    .clk_in    (CLOCK_IN),
    .arst_n_in (ARST_N_IN),
    .d_in      (ALARM_PIN_IN),
    .q_out     (pin_s)
  );

  // events are toggle changes seen after synchronising
  assign wr_ev  = wr_s ^ wr_seen_r;
  assign rd_ev  = rd_s ^ rd_seen_r;
  assign ara_ev = ara_s ^ ara_seen_r;

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wr_seen_r  <= 1'b0;
      rd_seen_r  <= 1'b0;
      ara_seen_r <= 1'b0;
    end else begin
      wr_seen_r  <= wr_s;
      rd_seen_r  <= rd_s;
      ara_seen_r <= ara_s;
    end
  end

  // control bits; link data moved on the same edge as its toggle, so is stable once the toggle is seen
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_r <= tsr_pkg::CTRL_RESET[tsr_pkg::BIT_TO_OFF:tsr_pkg::BIT_RES_LO];
    end else if (wr_ev) begin
      ctrl_r <= xf.ctrl_bits;
    end
  end

  // timeout-off and word size go out to the bus engine and converter
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      BUS_TIMEOUT_OFF_OUT <= 1'b0;
      RESOLUTION_SEL_OUT  <= tsr_pkg::RES_11;
    end else begin
      BUS_TIMEOUT_OFF_OUT <= ctrl_r[2];
      RESOLUTION_SEL_OUT  <= ctrl_r[1:0];
    end
  end

  // single conversion only from shutdown, and not while one runs
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CONV_START_OUT <= 1'b0;
    end else begin
      CONV_START_OUT <= ONE_SHOT_IN && SHUTDOWN_IN && !busy_r;
    end
  end

  // busy from start until the converter reports done
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      busy_r <= 1'b0;
    end else if (CONV_DONE_IN) begin
      busy_r <= 1'b0;
    end else if (CONV_START_OUT) begin
      busy_r <= 1'b1;
    end
  end

  // continuous mode always reports done
  assign done_flag = !SHUTDOWN_IN || !busy_r;

  // compare at the kept word size; limits carry no bits below 5
  assign temp_m  = TEMP_IN & tsr_pkg::res_mask(ctrl_r[1:0]);
  assign upper_m = UPPER_LIMIT_VALUE_IN & tsr_pkg::MASK_11;
  assign lower_m = LOWER_LIMIT_VALUE_IN & tsr_pkg::MASK_11;
  assign over_hit  = CONV_DONE_IN &&
                     ($signed(temp_m) > $signed(upper_m));
  assign under_hit = CONV_DONE_IN &&
                     ($signed(temp_m) < $signed(lower_m));

  // present side of each limit, refreshed per conversion
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      over_now_r  <= 1'b0;
      under_now_r <= 1'b0;
    end else if (CONV_DONE_IN) begin
      over_now_r  <= over_hit;
      under_now_r <= under_hit;
    end
  end

  // a read clears only if the host saw the current snapshot
  assign snap_ok = (ack_s == req_tgl_r) && (snap_r == live);

  // sticky flags; a new hit wins over a read in the same cycle
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      over_r <= 1'b0;
    end else if (over_hit) begin
      over_r <= 1'b1;
    end else if (rd_ev && snap_ok && !over_now_r && !CONV_DONE_IN) begin
      over_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      under_r <= 1'b0;
    end else if (under_hit) begin
      under_r <= 1'b1;
    end else if (rd_ev && snap_ok && !under_now_r && !CONV_DONE_IN) begin
      under_r <= 1'b0;
    end
  end

  // alarm latch; raising wins over any release in the same cycle
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      alarm_act_r <= 1'b0;
    end else if (over_hit) begin
      alarm_act_r <= 1'b1;
    end else if (under_hit || ALARM_CLEAR_CMD_IN || ara_ev) begin
      alarm_act_r <= 1'b0;
    end
  end

  // pin level: active level only when enabled and alarm held
  assign pin_level_nxt = (alarm_act_r && !ALARM_ENABLE_N_IN) ?
                         ALARM_POLARITY_SEL_IN :
                         !ALARM_POLARITY_SEL_IN;

  // open drain: pull low by enabling the driver, release for high
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ALARM_PIN_OUT      <= 1'b0;
      ALARM_PIN_OE_N_OUT <= 1'b1;
    end else begin
      ALARM_PIN_OUT      <= 1'b0;
      ALARM_PIN_OE_N_OUT <= pin_level_nxt;
    end
  end

  // status reads the pin as seen, so board pull-ups show too
  assign live = {pin_s, over_r, under_r, done_flag};

  // offer a new snapshot only after the last was taken
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      snap_r    <= tsr_pkg::CTRL_RESET[tsr_pkg::BIT_ALARM:tsr_pkg::BIT_DONE];
      req_tgl_r <= 1'b0;
    end else if (ack_s == req_tgl_r && snap_r != live) begin
      snap_r    <= live;
      req_tgl_r <= ~req_tgl_r;
    end
  end

  assign xf.req_tgl   = req_tgl_r;
  assign xf.stat_bits = snap_r;

  // core view of the whole register, reserved bit forced low
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      STATUS_OUT <= tsr_pkg::CTRL_RESET;
    end else begin
      STATUS_OUT <= {ctrl_r, 1'b0, live};
    end
  end
endmodule

// ---- hw/tsr_sync.sv ----
// three-stage synchroniser, output moves once stages two and three agree
module tsr_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // first stage feeds only the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r  <= RST;
      s2_r  <= RST;
      s3_r  <= RST;
      q_out <= RST;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ---- hw/tsr_xfer_if.sv ----
// signals crossing between link-clock and core-clock logic
interface tsr_xfer_if;
  logic       wr_tgl;     // control write event
  logic [2:0] ctrl_bits;  // written control bits, stable around toggle
  logic       rd_tgl;     // status register read event
  logic       ara_tgl;    // alert response completed
  logic       req_tgl;    // status snapshot offered
  logic [3:0] stat_bits;  // snapshot, stable until acknowledged
  logic       ack_tgl;    // snapshot taken

  modport link (output wr_tgl, ctrl_bits, rd_tgl, ara_tgl, ack_tgl,
                input  req_tgl, stat_bits);
  modport core (input  wr_tgl, ctrl_bits, rd_tgl, ara_tgl, ack_tgl,
                output req_tgl, stat_bits);
endinterface

// ---- verification/test_tsr_regs.sv ----
// self-checking bench for the control/status and identification registers
module test_tsr_regs;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic        clk = 1'b0, arst_n = 1'b1, shutdown = 1'b0, one_shot = 1'b0;
  logic        clr = 1'b0, pol = 1'b0, en_n = 1'b0, conv_done = 1'b0;
  logic [15:0] temp = 16'h0000, upper = 16'h1900, lower = 16'h0a00, rd;
  logic        conv_start, to_off, oe_n, pin_out, link_clk, wr_stb, rd_stb, ara;
  logic [1:0]  res;
  logic [7:0]  status, ptr, wr_data, d;
  logic [15:0] rd_data;
  wire         pin = oe_n ? 1'b1 : pin_out; // pull-up on open-drain line
  int          n_mismatch = 0, n_checks = 0;
  tsr_host_model host (.link_clk(link_clk), .ptr(ptr), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .ara_done(ara), .rd_data(rd_data));
  tsr_regs uut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .LINK_CLK_IN(link_clk),
    .PTR_IN(ptr), .WR_STB_IN(wr_stb), .WR_DATA_IN(wr_data),
    .RD_STB_IN(rd_stb), .ARA_DONE_IN(ara), .RD_DATA_OUT(rd_data),
    .SHUTDOWN_IN(shutdown), .ONE_SHOT_IN(one_shot),
    .ALARM_CLEAR_CMD_IN(clr), .ALARM_POLARITY_SEL_IN(pol),
    .ALARM_ENABLE_N_IN(en_n), .CONV_DONE_IN(conv_done), .TEMP_IN(temp),
    .UPPER_LIMIT_VALUE_IN(upper), .LOWER_LIMIT_VALUE_IN(lower),
    .CONV_START_OUT(conv_start), .BUS_TIMEOUT_OFF_OUT(to_off),
    .RESOLUTION_SEL_OUT(res), .STATUS_OUT(status), .ALARM_PIN_IN(pin),
    .ALARM_PIN_OUT(pin_out), .ALARM_PIN_OE_N_OUT(oe_n));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] pick(input logic [15:0] b, input int s);
    return b + 16'(s * ((($urandom % 8) + 1) << 5));
  endfunction
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
    return {w[7:5], 1'b0, 4'h9};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // one-cycle conversion end carrying a reading
  task automatic conv(input logic [15:0] t);
    temp = t;
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
    cyc(4);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few tens of microseconds the tests take
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'h2479));
    #2;
    arst_n = 1'b0; // a real falling edge, so the stopped link side resets too
    cyc(12);
    `CHK(status, 8'h08)
    arst_n = 1'b1;
    cyc(4);
    host.read_reg(8'h04, rd);
    `CHK(rd, 16'h0009)
    host.write_reg(8'h07, 8'hff);
    host.read_reg(8'h07, rd);
    `CHK(rd, 16'h5a32)
    host.read_reg(8'h05, rd);
    `CHK(rd, 16'h0000)
    $display("test reset and id done");
    for (int i = 0; i < 4; i++) begin
      d = {1'($urandom), 2'(i), 5'($urandom) & 5'h16};
      host.write_reg(8'h04, d);
      cyc(8);
      `CHK(to_off, d[7])
      `CHK(res, d[6:5])
      host.read_reg(8'h04, rd);
      `CHK(rd, {8'h00, exp_ctrl(d)})
    end
    host.write_reg(8'h04, 8'h00);
    $display("test control bits done");
    shutdown = 1'b1;
    cyc(3);
    one_shot = 1'b1;
    cyc(1);
    one_shot = 1'b0;
    cyc(2);
    `CHK(status[0], 1'b0)
    conv(upper);
    `CHK(status[0], 1'b1)
    `CHK(status[2:0], 3'b001)
    shutdown = 1'b0;
    one_shot = 1'b1;
    cyc(1);
    one_shot = 1'b0;
    repeat (3) begin
      `CHK(conv_start, 1'b0)
      cyc(1);
    end
    $display("test single conversion done");
    conv(pick(upper, 1));
    `CHK(status[2], 1'b1)
    `CHK(oe_n, 1'b0)
    host.read_reg(8'h04, rd);
    `CHK(rd[3:2], 2'b01)
    cyc(8);
    `CHK(status[2], 1'b1)
    conv(pick(lower, 1));
    host.read_reg(8'h04, rd);
    `CHK(rd[2], 1'b1)
    cyc(8);
    `CHK(status[2], 1'b0)
    `CHK(oe_n, 1'b0)
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
    `CHK(oe_n, 1'b1)
    $display("test over limit done");
    conv(pick(upper, 1));
    conv(pick(lower, -1));
    `CHK(status[1], 1'b1)
    `CHK(oe_n, 1'b1)
    host.read_reg(8'h04, rd);
    cyc(8);
    `CHK(status[2:1], 2'b01)
    conv(pick(lower, 1));
    host.read_reg(8'h04, rd);
    cyc(8);
    `CHK(status[2:1], 2'b00)
    $display("test under limit done");
    conv(pick(upper, 1));
    `CHK(oe_n, 1'b0)
    host.alert_resp();
    cyc(8);
    `CHK(oe_n, 1'b1)
    $display("test alert response done");
    en_n = 1'b1;
    conv(pick(upper, 1));
    cyc(8);
    `CHK({oe_n, status[3]}, 2'b11)
    en_n = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
    pol = 1'b1;
    cyc(10);
    `CHK({oe_n, status[3]}, 2'b00)
    conv(pick(upper, 1));
    cyc(8);
    `CHK({oe_n, status[3]}, 2'b11)
    $display("test alarm polarity done");
    // bits below the 11-bit limit only count at the finer word sizes
    host.write_reg(8'h04, 8'h60);
    cyc(8);
    `CHK(res, 2'h3)
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    conv(upper + 16'h0004);
    `CHK(oe_n, 1'b1)
    host.write_reg(8'h04, 8'h00);
    cyc(8);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    conv(upper + 16'h0004);
    `CHK(oe_n, 1'b0)
    $display("test resolution compare done");
    summarize();
  end
endmodule
bind tsr_regs tsr_regs_asserts chk (.CLOCK_IN(CLOCK_IN),
  .ARST_N_IN(ARST_N_IN), .SHUTDOWN_IN(SHUTDOWN_IN),
  .ONE_SHOT_IN(ONE_SHOT_IN), .ALARM_CLEAR_CMD_IN(ALARM_CLEAR_CMD_IN),
  .ALARM_POLARITY_SEL_IN(ALARM_POLARITY_SEL_IN),
  .ALARM_ENABLE_N_IN(ALARM_ENABLE_N_IN), .CONV_DONE_IN(CONV_DONE_IN),
  .TEMP_IN(TEMP_IN), .UPPER_LIMIT_VALUE_IN(UPPER_LIMIT_VALUE_IN),
  .LOWER_LIMIT_VALUE_IN(LOWER_LIMIT_VALUE_IN),
  .CONV_START_OUT(CONV_START_OUT), .STATUS_OUT(STATUS_OUT),
  .ALARM_PIN_IN(ALARM_PIN_IN), .ALARM_PIN_OUT(ALARM_PIN_OUT),
  .ALARM_PIN_OE_N_OUT(ALARM_PIN_OE_N_OUT));

// ---- verification/tsr_host_model.sv ----
// host model: drives the serial link's register port, owns the link clock
module tsr_host_model (
  output logic             link_clk,
  output logic      [7:0]  ptr,
  output logic             wr_stb,
  output logic      [7:0]  wr_data,
  output logic             rd_stb,
  output logic             ara_done,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b0;
  initial begin
    link_clk = 1'b0;
    ptr = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
    ara_done = 1'b0;
  end
  // clock only toggles inside a frame, idle bus has no clock
  always begin
    #24;
    link_clk = run ? ~link_clk : 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #2;
  endtask
  // released lines show the inverse, not the last value
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    run = 1'b1;
    tick(1);
    ptr = p;
    wr_data = d;
    wr_stb = 1'b1;
    tick(1);
    wr_stb = 1'b0;
    ptr = ~p;
    wr_data = ~d;
    tick(4);
    run = 1'b0;
  endtask
  // long settle so the status snapshot is current before sampling
  task automatic read_reg(input logic [7:0] p, output logic [15:0] d);
    run = 1'b1;
    tick(1);
    ptr = p;
    tick(20);
    d = rd_data;
    rd_stb = 1'b1;
    tick(1);
    rd_stb = 1'b0;
    ptr = ~p;
    tick(4);
    run = 1'b0;
  endtask
  task automatic alert_resp;
    run = 1'b1;
    tick(1);
    ara_done = 1'b1;
    tick(1);
    ara_done = 1'b0;
    tick(4);
    run = 1'b0;
  endtask
endmodule

// ---- verification/tsr_regs_asserts.sv ----
// concurrent checks on the core-clock ports of the register block
module tsr_regs_asserts (
  input wire logic        CLOCK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        SHUTDOWN_IN,
  input wire logic        ONE_SHOT_IN,
  input wire logic        ALARM_CLEAR_CMD_IN,
  input wire logic        ALARM_POLARITY_SEL_IN,
  input wire logic        ALARM_ENABLE_N_IN,
  input wire logic        CONV_DONE_IN,
  input wire logic [15:0] TEMP_IN,
  input wire logic [15:0] UPPER_LIMIT_VALUE_IN,
  input wire logic [15:0] LOWER_LIMIT_VALUE_IN,
  input wire logic        CONV_START_OUT,
  input wire logic [7:0]  STATUS_OUT,
  input wire logic        ALARM_PIN_IN,
  input wire logic        ALARM_PIN_OUT,
  input wire logic        ALARM_PIN_OE_N_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // low five bits zero so every word size keeps the reading unchanged
  sequence over_hit;
    CONV_DONE_IN && TEMP_IN[4:0] == 5'h00 &&
      $signed(TEMP_IN) > $signed({UPPER_LIMIT_VALUE_IN[15:5], 5'h00});
  endsequence
  sequence under_hit;
    CONV_DONE_IN && TEMP_IN[4:0] == 5'h00 &&
      $signed(TEMP_IN) < $signed({LOWER_LIMIT_VALUE_IN[15:5], 5'h00});
  endsequence
  sequence act_low;
    !ALARM_POLARITY_SEL_IN && !ALARM_ENABLE_N_IN;
  endsequence
  chk_pin_never_high: assert property (ALARM_PIN_OUT == 1'b0)
    else $error("alarm pin driven high");
  chk_reserved_zero: assert property (STATUS_OUT[4] == 1'b0)
    else $error("reserved status bit set");
  chk_oneshot_start: assert property (
    ONE_SHOT_IN && SHUTDOWN_IN |=> CONV_START_OUT)
    else $error("single conversion not started");
  chk_start_cause: assert property (
    CONV_START_OUT |-> $past(ONE_SHOT_IN) && $past(SHUTDOWN_IN))
    else $error("conversion started without request");
  chk_busy_done: assert property (
    CONV_START_OUT |-> ##[1:2] !STATUS_OUT[0])
    else $error("done flag high while converting");
  chk_done_sets: assert property (
    SHUTDOWN_IN && CONV_DONE_IN |-> ##[1:2] STATUS_OUT[0])
    else $error("done flag not set after conversion");
  chk_cont_done: assert property (
    !SHUTDOWN_IN [*3] |=> STATUS_OUT[0])
    else $error("done flag low in continuous mode");
  chk_over_flag: assert property (over_hit |-> ##[1:2] STATUS_OUT[2])
    else $error("over flag not set");
  chk_under_flag: assert property (under_hit |-> ##[1:2] STATUS_OUT[1])
    else $error("under flag not set");
  chk_alarm_raise: assert property (
    over_hit ##0 act_low |-> ##[1:3] !ALARM_PIN_OE_N_OUT)
    else $error("alarm not raised");
  chk_alarm_clear: assert property (
    ALARM_CLEAR_CMD_IN && !CONV_DONE_IN ##0 act_low
      |-> ##[1:3] ALARM_PIN_OE_N_OUT)
    else $error("alarm not released");
  chk_pin_status: assert property (
    $stable(ALARM_PIN_IN) [*6] |-> STATUS_OUT[3] == ALARM_PIN_IN)
    else $error("status bit does not follow pin");
endmodule
